// ==== ecad_pkg.sv ====
// Package: constants and types shared by the EEPROM client address decoder
package ecad_pkg;
  // Device type code expected in address bits 7..4; value is arbitrary
  localparam logic [3:0] ECAD_TYPE_CODE = 4'h5;
  // Field positions inside the device address byte
  localparam int ECAD_TYPE_MSB = 7;
  localparam int ECAD_TYPE_LSB = 4;
  localparam int ECAD_SEL_UPPER_POS = 3;
  localparam int ECAD_SEL_LOWER_POS = 2;
  localparam int ECAD_BIT9_POS = 2;
  localparam int ECAD_BIT8_POS = 1;
  localparam int ECAD_RW_POS = 0;
  // Array geometry per variant
  localparam int ECAD_ROW_BYTES = 16;
  localparam int ECAD_ROWS_4K = 32;
  localparam int ECAD_ROWS_8K = 64;
  localparam int ECAD_ADDR_W = 10;
  localparam logic [9:0] ECAD_SIZE_4K = 10'(ECAD_ROWS_4K * ECAD_ROW_BYTES);
  localparam logic [9:0] ECAD_SIZE_8K_M1 = 10'(ECAD_ROWS_8K * ECAD_ROW_BYTES - 1);
  // Bits per byte and the acknowledge slot
  localparam logic [3:0] ECAD_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ECAD_ACK_SLOT = 4'h9;
  // Reset values
  localparam logic [9:0] ECAD_ADDR_RST = 10'h000;
  localparam logic [7:0] ECAD_BYTE_RST = 8'h00;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV_BYTE,
    ST_DEV_ACK,
    ST_WORD_BYTE,
    ST_WORD_ACK,
    ST_DATA,
    ST_IGNORE
  } ecad_state_t;
endpackage

// ==== ecad_line_if.sv ====
// Interface: sampled bus lines and edge events from the line sampler
`timescale 1ns/1ps
`default_nettype none
interface ecad_line_if;
  logic clk_rise;
  logic clk_fall;
  logic start_seen;
  logic stop_seen;
  logic data_level;
  modport src (output clk_rise, output clk_fall, output start_seen, output stop_seen,
    output data_level);
  modport dst (input clk_rise, input clk_fall, input start_seen, input stop_seen,
    input data_level);
endinterface
`default_nettype wire

// ==== ecad_sampler.sv ====
// Line sampler: synchronises serial clock and data, finds edges and start/stop
`timescale 1ns/1ps
`default_nettype none
module ecad_sampler
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  ecad_line_if.src lines
);
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_last_reg;
  logic sda_last_reg;

  // Two-stage synchronisers; first stage feeds only the second
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_last_reg <= 1'b1;
      sda_last_reg <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_last_reg <= scl_sync_reg[1];
      sda_last_reg <= sda_sync_reg[1];
    end
  end

  // Edge and condition detection on the synchronised copies
  assign lines.clk_rise = scl_sync_reg[1] && !scl_last_reg;
  assign lines.clk_fall = !scl_sync_reg[1] && scl_last_reg;
  assign lines.start_seen = scl_sync_reg[1] && scl_last_reg && sda_last_reg && !sda_sync_reg[1];
  assign lines.stop_seen = scl_sync_reg[1] && scl_last_reg && !sda_last_reg && sda_sync_reg[1];
  assign lines.data_level = sda_sync_reg[1];
endmodule
`default_nettype wire

// ==== ecad_decoder.sv ====
// Top: two-wire EEPROM client device/word address decoder
// Contract
// - 4K variant: 32 rows of 16 bytes
// - 8K variant: 64 rows of 16 bytes
// - Address byte after start gates all access
// - Bits 7..4 compared to type code
// - 4K: bits 3,2 against select pins
// - 4K: bit 1 becomes address bit 8
// - Bit 0 one reads, zero writes
// - Acknowledge match in ninth clock, else silent
// - Floating select pin compares as zero
// - Pinless package compares select bits with zero
// - Word address byte follows device byte
// - 8K: bits 2,1 become address bits 9,8
// - 8K: only bit 3 against select pin
// - Word byte gives address bits 7..0
// - MSB first, sample rising, drive falling
// - Ack low through ninth high, then release
`timescale 1ns/1ps
`default_nettype none
module ecad_decoder
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic variant_8k,
  input wire logic pinless_pkg,
  input wire logic client_select_upper,
  input wire logic client_select_lower,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic addr_match,
  output logic read_sel,
  output logic word_addr_valid,
  output logic [ecad_pkg::ECAD_ADDR_W-1:0] word_addr,
  output logic word_addr_bit8,
  output logic word_addr_bit9
);
  import ecad_pkg::*;

  ecad_line_if lines();
  ecad_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [1:0] upper_sync_reg;
  logic [1:0] lower_sync_reg;
  logic [1:0] variant_sync_reg;
  logic [1:0] pinless_sync_reg;
  logic ack_drive_reg;
  logic match_reg;
  logic read_reg;
  logic addr_valid_reg;
  logic [ECAD_ADDR_W-1:0] addr_reg;
  logic sel_upper;
  logic sel_lower;
  logic dev_match;
  logic [7:0] byte_in;
  logic byte_done;

  // ==========================================================
  // Line sampling
  ecad_sampler u_sampler
  (
    .mclk(mclk),
    .resetn(resetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .lines(lines)
  );

  // Select pins and variant straps are pins too, so synchronise them
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      upper_sync_reg <= 2'h0;
      lower_sync_reg <= 2'h0;
      variant_sync_reg <= 2'h0;
      pinless_sync_reg <= 2'h0;
    end
    else
    begin
      upper_sync_reg <= {upper_sync_reg[0], client_select_upper};
      lower_sync_reg <= {lower_sync_reg[0], client_select_lower};
      variant_sync_reg <= {variant_sync_reg[0], variant_8k};
      pinless_sync_reg <= {pinless_sync_reg[0], pinless_pkg};
    end
  end

  // ==========================================================
  // Address compare
  // Absent or floating pins read as zero; pinless package forces zero
  assign sel_upper = pinless_sync_reg[1] ? 1'b0 : upper_sync_reg[1];
  assign sel_lower = pinless_sync_reg[1] ? 1'b0 : lower_sync_reg[1];
  assign byte_in = {shift_reg[6:0], lines.data_level};
  assign byte_done = lines.clk_rise && (bit_cnt_reg == ECAD_BITS_PER_BYTE - 4'h1);

  // Type code always; 8K checks only the upper select bit
  always_comb
  begin
    dev_match = (byte_in[ECAD_TYPE_MSB:ECAD_TYPE_LSB] == ECAD_TYPE_CODE);
    if (byte_in[ECAD_SEL_UPPER_POS] != sel_upper)
    begin
      dev_match = 1'b0;
    end
    if (!variant_sync_reg[1] && (byte_in[ECAD_SEL_LOWER_POS] != sel_lower))
    begin
      dev_match = 1'b0;
    end
  end

  // ==========================================================
  // Protocol sequencing
  // A start anywhere restarts decoding, even from the ignore state
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= ECAD_BYTE_RST;
    end
    else if (lines.start_seen)
    begin
      state_reg <= ST_DEV_BYTE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= ECAD_BYTE_RST;
    end
    else if (lines.stop_seen)
    begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE, ST_IGNORE, ST_DATA:
        begin
          bit_cnt_reg <= 4'h0;
        end
        ST_DEV_BYTE, ST_WORD_BYTE:
        begin
          if (lines.clk_rise)
          begin
            shift_reg <= byte_in;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (byte_done && state_reg == ST_DEV_BYTE)
          begin
            state_reg <= dev_match ? ST_DEV_ACK : ST_IGNORE;
          end
          else if (byte_done)
          begin
            state_reg <= ST_WORD_ACK;
          end
        end
        ST_DEV_ACK, ST_WORD_ACK:
        begin
          if (lines.clk_rise)
          begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          // Leave after the ninth clock falls
          if (lines.clk_fall && bit_cnt_reg == ECAD_ACK_SLOT)
          begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == ST_DEV_ACK && !read_reg)
            begin
              state_reg <= ST_WORD_BYTE;
            end
            else
            begin
              state_reg <= ST_DATA;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Acknowledge driver
  // Drive low from the eighth falling edge to the ninth; on falls only
  always_ff @(posedge mclk)
  begin
    if (!resetn || lines.start_seen || lines.stop_seen)
    begin
      ack_drive_reg <= 1'b0;
    end
    else if (lines.clk_fall)
    begin
      ack_drive_reg <= (state_reg == ST_DEV_ACK || state_reg == ST_WORD_ACK) &&
        (bit_cnt_reg == ECAD_BITS_PER_BYTE);
    end
  end

  // Open drain: output always low, enable (active low) only while acking
  // Set on the same fall as the ack flag: one stage less keeps the line low
  // before a fast host raises the ninth clock, so no false start is seen
  always_ff @(posedge mclk)
  begin
    if (!resetn || lines.start_seen || lines.stop_seen)
    begin
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else if (lines.clk_fall)
    begin
      sda_out <= 1'b0;
      sda_oe_n <= !((state_reg == ST_DEV_ACK || state_reg == ST_WORD_ACK) &&
        (bit_cnt_reg == ECAD_BITS_PER_BYTE));
    end
  end

  // ==========================================================
  // Decoded address and direction
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      match_reg <= 1'b0;
      read_reg <= 1'b0;
      addr_valid_reg <= 1'b0;
      addr_reg <= ECAD_ADDR_RST;
    end
    else if (lines.start_seen)
    begin
      match_reg <= 1'b0;
      addr_valid_reg <= 1'b0;
    end
    else if (byte_done && state_reg == ST_DEV_BYTE && dev_match)
    begin
      match_reg <= 1'b1;
      read_reg <= byte_in[ECAD_RW_POS];
      addr_reg[8] <= byte_in[ECAD_BIT8_POS];
      // 9-bit space in 4K keeps bit 9 at zero
      addr_reg[9] <= variant_sync_reg[1] ? byte_in[ECAD_BIT9_POS] : 1'b0;
    end
    else if (byte_done && state_reg == ST_WORD_BYTE)
    begin
      addr_reg[7:0] <= byte_in;
      addr_valid_reg <= 1'b1;
    end
  end

  // Flop copies of decode results for the ports
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      addr_match <= 1'b0;
      read_sel <= 1'b0;
      word_addr_valid <= 1'b0;
      word_addr <= ECAD_ADDR_RST;
      word_addr_bit8 <= 1'b0;
      word_addr_bit9 <= 1'b0;
    end
    else
    begin
      addr_match <= match_reg;
      read_sel <= read_reg;
      word_addr_valid <= addr_valid_reg;
      word_addr <= addr_reg;
      word_addr_bit8 <= addr_reg[8];
      word_addr_bit9 <= addr_reg[9];
    end
  end

  // ==========================================================
  // Checks
  sequence dev_byte_end;
    state_reg == ST_DEV_BYTE && byte_done && !lines.start_seen && !lines.stop_seen;
  endsequence

  a_reject_ignores: assert property (@(posedge mclk) disable iff (!resetn)
    dev_byte_end and !dev_match |=> state_reg == ST_IGNORE)
    else $error("rejected address not ignored");
  a_ignore_until_start: assert property (@(posedge mclk) disable iff (!resetn)
    state_reg == ST_IGNORE && !lines.start_seen && !lines.stop_seen |=> state_reg == ST_IGNORE)
    else $error("left ignore without start");
  a_type_checked: assert property (@(posedge mclk) disable iff (!resetn)
    dev_byte_end and (byte_in[7:4] != ECAD_TYPE_CODE) |=> !match_reg)
    else $error("wrong type code matched");
  a_start_restarts: assert property (@(posedge mclk) disable iff (!resetn)
    lines.start_seen |=> state_reg == ST_DEV_BYTE && !match_reg)
    else $error("start did not restart decode");
  a_no_drive_reject: assert property (@(posedge mclk) disable iff (!resetn)
    state_reg == ST_IGNORE |=> ##1 sda_oe_n)
    else $error("bus driven after reject");
  a_rw_capture: assert property (@(posedge mclk) disable iff (!resetn)
    dev_byte_end and dev_match |=> read_reg == $past(byte_in[0]))
    else $error("direction bit not captured");
  a_bit9_4k: assert property (@(posedge mclk) disable iff (!resetn)
    dev_byte_end and dev_match and !variant_sync_reg[1] |=> addr_reg < ECAD_SIZE_4K)
    else $error("address out of range");
  a_ack_window: assert property (@(posedge mclk) disable iff (!resetn)
    ack_drive_reg && !lines.start_seen && !lines.stop_seen
    |-> state_reg == ST_DEV_ACK || state_reg == ST_WORD_ACK)
    else $error("ack outside ack slot");
  a_word_low: assert property (@(posedge mclk) disable iff (!resetn)
    state_reg == ST_WORD_BYTE && byte_done && !lines.start_seen && !lines.stop_seen
    |=> addr_reg[7:0] == $past(byte_in) && addr_valid_reg)
    else $error("word address not captured");
  a_ack_on_fall: assert property (@(posedge mclk) disable iff (!resetn)
    $fell(sda_oe_n) |-> $past(lines.clk_fall))
    else $error("ack driven off a clock fall");
  a_ack_needs_match: assert property (@(posedge mclk) disable iff (!resetn)
    !sda_oe_n |-> match_reg)
    else $error("line driven without a match");
endmodule
`default_nettype wire

// ==== ecad_host_model.sv ====
// Two-wire bus host model driving serial clock and data
`timescale 1ns/1ps
`default_nettype none
module ecad_host_model
(
  input wire logic mclk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  // ==========
  // Bus phases
  // Idle: both lines high, clock stands still between frames
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Wait a number of mclk edges
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Start, also usable as repeated start from clock low
  task automatic start_cond();
    tick(1);
    sda_drv <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b0;
    tick(4);
  endtask
  // Stop ends the frame and leaves the bus idle
  task automatic stop_cond();
    tick(1);
    scl <= 1'b0;
    tick(2);
    sda_drv <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b1;
    tick(4);
  endtask
  // One 200 ns clock: data changes mid low phase, line read late in high phase
  task automatic bit_slot(input logic d, output logic s);
    tick(1);
    scl <= 1'b0;
    tick(2);
    sda_drv <= d;
    tick(2);
    scl <= 1'b1;
    tick(3);
    s = sda_line;
  endtask
  // Byte MSB first, then released ninth clock; extra low time lets the ack drop
  task automatic send_byte(input logic [7:0] b, output logic ack_n);
    for (int i = 7; i >= 0; i--)
    begin
      bit_slot(b[i], ack_n);
    end
    bit_slot(1'b1, ack_n);
    tick(1);
    scl <= 1'b0;
    tick(7);
  endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the client address decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ecad_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic variant_8k = 1'b0;
  logic pinless_pkg = 1'b0;
  logic sel_up = 1'b0;
  logic sel_lo = 1'b0;
  logic scl;
  logic sda_drv;
  logic sda_out;
  logic sda_oe_n;
  logic addr_match;
  logic read_sel;
  logic word_addr_valid;
  logic [ECAD_ADDR_W-1:0] word_addr;
  logic b8;
  logic b9;
  logic ack_n;
  int fail_count = 0;
  int total_checks = 0;
  // Open-drain line with pull-up
  wire logic sda_line = sda_drv & (sda_oe_n | sda_out);
  // ==========
  // Instances
  ecad_decoder uut (.mclk(mclk), .resetn(resetn), .variant_8k(variant_8k),
    .pinless_pkg(pinless_pkg), .client_select_upper(sel_up), .client_select_lower(sel_lo),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .addr_match(addr_match), .read_sel(read_sel), .word_addr_valid(word_addr_valid),
    .word_addr(word_addr), .word_addr_bit8(b8), .word_addr_bit9(b9));
  ecad_host_model host (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
  // 40 MHz clock
  initial
  begin
    forever #12.5 mclk = ~mclk;
  end
  // ==========
  // Helpers
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Static straps change only between frames, then settle through the synchronisers
  task automatic cfg(input logic v, input logic p, input logic u, input logic l);
    @(posedge mclk);
    variant_8k <= v;
    pinless_pkg <= p;
    sel_up <= u;
    sel_lo <= l;
    repeat (4) @(posedge mclk);
  endtask
  // Start plus device byte, ack compared
  task automatic dev(input logic [7:0] b, input logic exp_n);
    host.start_cond();
    host.send_byte(b, ack_n);
    check(ack_n, exp_n);
    check(sda_line, 1'b1);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_4k_write();
    cfg(1'b0, 1'b0, 1'b1, 1'b0);
    dev({ECAD_TYPE_CODE, 4'ha}, 1'b0);
    check(addr_match, 1'b1);
    check(read_sel, 1'b0);
    check(b8, 1'b1);
    host.send_byte(8'h5a, ack_n);
    check(ack_n, 1'b0);
    check(word_addr_valid, 1'b1);
    check(word_addr, 10'h15a);
    check(b9, 1'b0);
    host.stop_cond();
    $display("test 4k write done");
  endtask
  // Select mismatch, then wrong type, then a fresh match after restart
  task automatic t_reject();
    cfg(1'b0, 1'b0, 1'b1, 1'b1);
    dev({ECAD_TYPE_CODE, 4'h8}, 1'b1);
    check(addr_match, 1'b0);
    host.send_byte(8'h00, ack_n);
    check(ack_n, 1'b1);
    check(word_addr_valid, 1'b0);
    dev({ECAD_TYPE_CODE ^ 4'h1, 4'hc}, 1'b1);
    dev({ECAD_TYPE_CODE, 4'hd}, 1'b0);
    check(read_sel, 1'b1);
    host.stop_cond();
    $display("test reject done");
  endtask
  // Larger variant: bits 2,1 give address bits 9,8, then an upper select mismatch is refused
  task automatic t_8k();
    cfg(1'b1, 1'b0, 1'b0, 1'b1);
    dev({ECAD_TYPE_CODE, 4'h6}, 1'b0);
    check(b9, 1'b1);
    check(b8, 1'b1);
    host.send_byte(8'hff, ack_n);
    check(word_addr, 10'h3ff);
    dev({ECAD_TYPE_CODE, 4'he}, 1'b1);
    host.stop_cond();
    $display("test 8k done");
  endtask
  // Pinless package compares against zero whatever the pins show
  task automatic t_pinless();
    cfg(1'b0, 1'b1, 1'b1, 1'b1);
    dev({ECAD_TYPE_CODE, 4'hc}, 1'b1);
    dev({ECAD_TYPE_CODE, 4'h1}, 1'b0);
    check(read_sel, 1'b1);
    host.stop_cond();
    $display("test pinless done");
  endtask
  // ==========
  // Main sequence
  initial
  begin
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    t_4k_write();
    t_reject();
    t_8k();
    t_pinless();
    stop_test();
  end
  // Watchdog against a hung run
  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    $display("BAD t=%0t timeout", $time);
    stop_test();
  end
endmodule
`default_nettype wire
